// *** umcl_modem_ctrl.sv ***
/*
 * Modem-control and loopback block of a FIFO serial port: the modem line
 * control register, the loop interrupt enable and interrupt enable
 * registers, handshake outputs, interrupt gating and internal loopback.
 * Assumes the transmitter and receiver run on sys_clk, that modem and
 * receive pins are asynchronous and idle high, and an Avalon-MM master.
 */
// Notes on behaviour
// - Reserved bits 7..5 read one, writes ignored
// - Bit 4 selects loopback test mode
// - Loopback feeds transmit stream into receiver
// - Loopback holds transmit pin at one
// - Loopback ignores external receive pin
// - Loopback drives modem inputs from modem outputs
// - Loopback interrupt gated by loop enable, ier
// - Normal mode: bit 3 gates port interrupt
// - Bit 2 only feeds ring input in loopback
// - Bit 1 set drives request-to-send low
// - Bit 0 set drives terminal-ready low
module umcl_modem_ctrl #(
    parameter int IRQ_W = umcl_pkg::UMCL_IER_W
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [3:0] avs_address,
    input wire logic avs_read,
    input wire logic avs_write,
    input wire logic [31:0] avs_writedata,
    input wire logic [3:0] avs_byteenable,
    output logic [31:0] avs_readdata,
    output logic avs_waitrequest,
    input wire logic tx_serial_in,
    output logic tx_pin,
    input wire logic rx_pin,
    output logic rx_data_out,
    input wire logic cts_pin_n,
    input wire logic dsr_pin_n,
    input wire logic ri_pin_n,
    input wire logic dcd_pin_n,
    output logic rts_n,
    output logic dtr_n,
    output logic cts_n_int,
    output logic dsr_n_int,
    output logic ri_n_int,
    output logic dcd_n_int,
    input wire logic [IRQ_W-1:0] irq_sources,
    output logic port_irq,
    output logic loop_active
);
    import umcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // Declarations
    umcl_bus_state_type bus_state;
    umcl_bus_state_type next_bus_state;
    logic [UMCL_MLC_W-1:0] mlc;
    logic wrap_ie;
    logic [IRQ_W-1:0] ier;
    logic [4:0] pin_sync;
    logic rx_sync;
    logic cts_sync_n;
    logic dsr_sync_n;
    logic ri_sync_n;
    logic dcd_sync_n;
    logic bus_req;
    logic bus_take;
    logic wr_take;
    logic lane0;
    logic sel_mlc;
    logic sel_spc;
    logic sel_ier;
    logic sel_msr;
    logic loop_on;
    logic next_cts_n;
    logic next_dsr_n;
    logic next_ri_n;
    logic next_dcd_n;
    logic next_rx;
    logic irq_pending;
    logic next_irq;
    logic [31:0] next_readdata;

    // Address match used by every select below
    function automatic logic hit(input logic [3:0] addr,
                                 input logic [3:0] ofs);
        hit = (addr == ofs);
    endfunction : hit

    ////////////////////////////////////////////////////////////////////////
    // Pin synchronisers; nothing reads a raw pin
    umcl_pin_sync #(
        .WIDTH(5)
    ) u_pin_sync (
        .sys_clk(sys_clk),
        .resetn(resetn),
        .clk_en(clk_en),
        .async_in({dcd_pin_n, ri_pin_n, dsr_pin_n, cts_pin_n, rx_pin}),
        .sync_out(pin_sync)
    );

    assign rx_sync = pin_sync[0];
    assign cts_sync_n = pin_sync[1];
    assign dsr_sync_n = pin_sync[2];
    assign ri_sync_n = pin_sync[3];
    assign dcd_sync_n = pin_sync[4];

    ////////////////////////////////////////////////////////////////////////
    // Bus decode; a request is seen in IDLE, accepted in ACK
    assign bus_req = avs_read | avs_write;
    assign bus_take = clk_en & bus_req & ~avs_waitrequest;
    assign wr_take = bus_take & avs_write;
    assign lane0 = avs_byteenable[0];
    assign sel_mlc = hit(avs_address, UMCL_OFS_MLC);
    assign sel_spc = hit(avs_address, UMCL_OFS_SPC);
    assign sel_ier = hit(avs_address, UMCL_OFS_IER);
    assign sel_msr = hit(avs_address, UMCL_OFS_MSR);

    // Read mux; unmapped offsets read zero
    always_comb begin
        next_readdata = 32'h0000_0000;
        if (sel_mlc) begin
            next_readdata[7:0] = {UMCL_MLC_RSVD, mlc};
        end else if (sel_spc) begin
            next_readdata[UMCL_SPC_WRAP_IE] = wrap_ie;
        end else if (sel_ier) begin
            next_readdata[IRQ_W-1:0] = ier;
        end else if (sel_msr) begin
            next_readdata[UMCL_MSR_CTS] = ~cts_n_int;
            next_readdata[UMCL_MSR_DSR] = ~dsr_n_int;
            next_readdata[UMCL_MSR_RI] = ~ri_n_int;
            next_readdata[UMCL_MSR_DCD] = ~dcd_n_int;
        end
    end

    // Two-state handshake: one wait cycle, then one accept cycle
    always_comb begin
        next_bus_state = bus_state;
        case (bus_state)
            UMCL_BUS_IDLE: begin
                if (bus_req) begin
                    next_bus_state = UMCL_BUS_ACK;
                end
            end
            UMCL_BUS_ACK: begin
                next_bus_state = UMCL_BUS_IDLE;
            end
            default: begin
                next_bus_state = UMCL_BUS_IDLE;
            end
        endcase
    end

    // Handshake registers; read data latched as waitrequest drops
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            bus_state <= UMCL_BUS_IDLE;
            avs_waitrequest <= 1'b1;
            avs_readdata <= 32'h0000_0000;
        end else if (clk_en) begin
            bus_state <= next_bus_state;
            avs_waitrequest <= (next_bus_state != UMCL_BUS_ACK);
            if (bus_state == UMCL_BUS_IDLE && avs_read) begin
                avs_readdata <= next_readdata;
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Control registers; only byte lane 0 carries fields
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            mlc <= UMCL_MLC_RESET;
            wrap_ie <= UMCL_SPC_RESET;
            ier <= UMCL_IER_RESET;
        end else if (wr_take && lane0) begin
            if (sel_mlc) begin
                mlc <= avs_writedata[UMCL_MLC_W-1:0];
            end else if (sel_spc) begin
                wrap_ie <= avs_writedata[UMCL_SPC_WRAP_IE];
            end else if (sel_ier) begin
                ier <= avs_writedata[IRQ_W-1:0];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Loopback selection of receive data and modem inputs
    assign loop_on = mlc[UMCL_MLC_LOOP];
    // The transmit stream is taken before the pin flop, so the echo
    // does not wait on the pin path; pin sync latency is skipped too
    assign next_rx = loop_on ? tx_serial_in : rx_sync;
    // Inputs follow the output pin levels, active low like the pins
    assign next_dsr_n = loop_on ? ~mlc[UMCL_MLC_DTR] : dsr_sync_n;
    assign next_cts_n = loop_on ? ~mlc[UMCL_MLC_RTS] : cts_sync_n;
    assign next_ri_n = loop_on ? ~mlc[UMCL_MLC_AUX] : ri_sync_n;
    assign next_dcd_n = loop_on ? ~mlc[UMCL_MLC_GATE] : dcd_sync_n;

    ////////////////////////////////////////////////////////////////////////
    // Interrupt gate: loop enable in test mode, bit 3 otherwise
    assign irq_pending = |(ier & irq_sources);
    assign next_irq = irq_pending
        & (loop_on ? wrap_ie : mlc[UMCL_MLC_GATE]);

    ////////////////////////////////////////////////////////////////////////
    // Output flops; pins idle high until released from reset
    always_ff @(posedge sys_clk) begin
        if (!resetn) begin
            tx_pin <= UMCL_PIN_IDLE;
            rx_data_out <= UMCL_PIN_IDLE;
            rts_n <= UMCL_PIN_IDLE;
            dtr_n <= UMCL_PIN_IDLE;
            cts_n_int <= UMCL_PIN_IDLE;
            dsr_n_int <= UMCL_PIN_IDLE;
            ri_n_int <= UMCL_PIN_IDLE;
            dcd_n_int <= UMCL_PIN_IDLE;
            port_irq <= 1'b0;
            loop_active <= 1'b0;
        end else if (clk_en) begin
            tx_pin <= loop_on ? UMCL_PIN_IDLE : tx_serial_in;
            rx_data_out <= next_rx;
            rts_n <= ~mlc[UMCL_MLC_RTS];
            dtr_n <= ~mlc[UMCL_MLC_DTR];
            cts_n_int <= next_cts_n;
            dsr_n_int <= next_dsr_n;
            ri_n_int <= next_ri_n;
            dcd_n_int <= next_dcd_n;
            port_irq <= next_irq;
            loop_active <= loop_on;
        end
    end

    ////////////////////////////////////////////////////////////////////////
    // Assertions
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (!resetn);

    property p_rsvd_ones;
        clk_en && bus_state == UMCL_BUS_IDLE && avs_read && sel_mlc
            |=> avs_readdata[7:5] == 3'h7;
    endproperty
    a_rsvd_ones: assert property (p_rsvd_ones)
        else $error("reserved modem control bits not read as one");

    property p_loop_write;
        wr_take && lane0 && sel_mlc
            |=> loop_on == $past(avs_writedata[UMCL_MLC_LOOP]);
    endproperty
    a_loop_write: assert property (p_loop_write)
        else $error("loopback bit did not follow the write");

    property p_loop_rx;
        clk_en && loop_on |=> rx_data_out == $past(tx_serial_in);
    endproperty
    a_loop_rx: assert property (p_loop_rx)
        else $error("receiver not fed from transmit stream");

    // The pin flop takes the mode seen at the same edge as the stream
    property p_loop_tx_high;
        clk_en && loop_on |=> tx_pin == 1'b1;
    endproperty
    a_loop_tx_high: assert property (p_loop_tx_high)
        else $error("transmit pin not held high in loopback");

    property p_normal_rx;
        clk_en && !loop_on |=> rx_data_out == $past(rx_sync);
    endproperty
    a_normal_rx: assert property (p_normal_rx)
        else $error("receive path selection wrong");

    property p_loop_modem;
        clk_en && loop_on |=> dsr_n_int == dtr_n && cts_n_int == rts_n
            && ri_n_int == !$past(mlc[UMCL_MLC_AUX])
            && dcd_n_int == !$past(mlc[UMCL_MLC_GATE]);
    endproperty
    a_loop_modem: assert property (p_loop_modem)
        else $error("modem inputs not driven from outputs");

    property p_loop_irq;
        clk_en && loop_on |=> port_irq ==
            ($past(wrap_ie) && $past(irq_pending));
    endproperty
    a_loop_irq: assert property (p_loop_irq)
        else $error("interrupt passed without loop enable");

    property p_gate_irq;
        clk_en && !loop_on |=> port_irq ==
            ($past(mlc[UMCL_MLC_GATE]) && $past(irq_pending));
    endproperty
    a_gate_irq: assert property (p_gate_irq)
        else $error("interrupt gate bit not honoured");

    property p_aux_normal;
        clk_en && !loop_on |=> ri_n_int == $past(ri_sync_n);
    endproperty
    a_aux_normal: assert property (p_aux_normal)
        else $error("auxiliary bit leaked into ring input");

    property p_rts_level;
        clk_en |=> rts_n == !$past(mlc[UMCL_MLC_RTS]);
    endproperty
    a_rts_level: assert property (p_rts_level)
        else $error("request-to-send level wrong");

    property p_dtr_level;
        clk_en |=> dtr_n == !$past(mlc[UMCL_MLC_DTR]);
    endproperty
    a_dtr_level: assert property (p_dtr_level)
        else $error("terminal-ready level wrong");

    property p_bus_answer;
        clk_en && bus_state == UMCL_BUS_IDLE && bus_req
            |=> !avs_waitrequest;
    endproperty
    a_bus_answer: assert property (p_bus_answer)
        else $error("bus request not answered in one cycle");

    // Clock enable low holds every flop where it stands
    property p_clk_freeze;
        !clk_en |=> $stable(mlc) && $stable(tx_pin) && $stable(port_irq)
            && $stable(bus_state) && $stable(avs_waitrequest);
    endproperty
    a_clk_freeze: assert property (p_clk_freeze)
        else $error("state moved while clock enable was low");

    // Main scenarios
    property p_cov_loop_echo;
        loop_on && clk_en ##1 rx_data_out == 1'b0;
    endproperty
    c_cov_loop_echo: cover property (p_cov_loop_echo);

    property p_cov_irq_normal;
        !loop_on && port_irq;
    endproperty
    c_cov_irq_normal: cover property (p_cov_irq_normal);

    property p_cov_irq_loop;
        loop_on && port_irq;
    endproperty
    c_cov_irq_loop: cover property (p_cov_irq_loop);

    property p_cov_mlc_read;
        bus_take && avs_read && sel_mlc;
    endproperty
    c_cov_mlc_read: cover property (p_cov_mlc_read);

endmodule : umcl_modem_ctrl

// *** umcl_modem_ctrl_tb.sv ***
/*
 * Self-checking bench: register model, pin model and random traffic.
 * Assumes the modem partner model and one 50 MHz clock.
 */
module umcl_modem_ctrl_tb import umcl_pkg::*;;
    timeunit 1ns;
    timeprecision 1ps;
    logic sys_clk = 1'b0;
    logic resetn = 1'b0;
    logic [3:0] avs_address = 4'h0;
    logic avs_read = 1'b0;
    logic avs_write = 1'b0;
    logic [31:0] avs_writedata = 32'h0;
    logic [3:0] avs_byteenable = 4'hF;
    logic [31:0] avs_readdata;
    logic avs_waitrequest;
    logic tx_serial_in = 1'b1;
    logic clk_en = 1'b1;
    logic tx_pin, rx_pin, rx_data_out, rts_n, dtr_n, port_irq, loop_active;
    logic cts_pin_n, dsr_pin_n, ri_pin_n, dcd_pin_n;
    logic cts_n_int, dsr_n_int, ri_n_int, dcd_n_int;
    logic [3:0] irq_sources = 4'h0;
    logic slow = 1'b0;
    logic flip = 1'b0;
    logic ext_rx = 1'b1;
    logic ext_ri_n = 1'b1;
    logic ext_dcd_n = 1'b1;
    logic [4:0] m_mlc = 5'h00;
    logic m_wrap = 1'b0;
    logic [3:0] m_ier = 4'h0;
    logic [31:0] q;
    int n_mismatch = 0;
    int tests_run = 0;

    // 50 MHz clock
    always #10 sys_clk = ~sys_clk;

    umcl_modem_ctrl #(.IRQ_W(4)) dut (.sys_clk(sys_clk), .resetn(resetn),
        .clk_en(clk_en), .avs_address(avs_address), .avs_read(avs_read),
        .avs_write(avs_write), .avs_writedata(avs_writedata),
        .avs_byteenable(avs_byteenable), .avs_readdata(avs_readdata),
        .avs_waitrequest(avs_waitrequest), .tx_serial_in(tx_serial_in),
        .tx_pin(tx_pin), .rx_pin(rx_pin), .rx_data_out(rx_data_out),
        .cts_pin_n(cts_pin_n), .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n),
        .dcd_pin_n(dcd_pin_n), .rts_n(rts_n), .dtr_n(dtr_n),
        .cts_n_int(cts_n_int), .dsr_n_int(dsr_n_int), .ri_n_int(ri_n_int),
        .dcd_n_int(dcd_n_int), .irq_sources(irq_sources),
        .port_irq(port_irq), .loop_active(loop_active));

    umcl_modem_partner modem (.sys_clk(sys_clk), .slow(slow), .flip(flip),
        .ext_rx(ext_rx), .ext_ri_n(ext_ri_n), .ext_dcd_n(ext_dcd_n),
        .rts_n(rts_n), .dtr_n(dtr_n), .cts_pin_n(cts_pin_n),
        .dsr_pin_n(dsr_pin_n), .ri_pin_n(ri_pin_n), .dcd_pin_n(dcd_pin_n),
        .rx_pin(rx_pin));

    ////////////////////////////////////////
    // Comparison and closing tasks
    task automatic chk_word(input string what, input logic [31:0] e,
                            input logic [31:0] g);
        tests_run++;
        if (g !== e) begin
            n_mismatch++;
            $display("Error %s expected %h seen %h", what, e, g);
        end
    endtask : chk_word

    task automatic chk_bit(input string what, input logic e, input logic g);
        chk_word(what, {31'h0, e}, {31'h0, g});
    endtask : chk_bit

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_mismatch);
        if (n_mismatch == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask : test_done

    ////////////////////////////////////////
    // Avalon master: hold the request until waitrequest is sampled low
    task automatic bus(input logic wr, input logic [3:0] a,
                       input logic [31:0] d, input logic [3:0] be);
        int n;
        @(posedge sys_clk);
        avs_address <= a;
        avs_write <= wr;
        avs_read <= !wr;
        avs_writedata <= d;
        avs_byteenable <= be;
        n = 0;
        do begin
            @(posedge sys_clk);
            n++;
        end while (avs_waitrequest !== 1'b0 && n < 20);
        if (avs_waitrequest !== 1'b0) begin
            n_mismatch++;
            $display("Error waitrequest expected 0 seen %b", avs_waitrequest);
            test_done();
        end
        q = avs_readdata;
        avs_read <= 1'b0;
        avs_write <= 1'b0;
    endtask : bus

    // Model write; dropped unless byte lane 0 is enabled
    task automatic wr(input logic [3:0] a, input logic [31:0] d,
                      input logic [3:0] be);
        bus(1'b1, a, d, be);
        if (be[0] && a == UMCL_OFS_MLC) m_mlc = d[4:0];
        if (be[0] && a == UMCL_OFS_SPC) m_wrap = d[UMCL_SPC_WRAP_IE];
        if (be[0] && a == UMCL_OFS_IER) m_ier = d[3:0];
    endtask : wr

    // Expected internal modem inputs, {dcd, ri, dsr, cts}, active low
    function automatic logic [3:0] e_ints();
        if (m_mlc[4]) return ~{m_mlc[3:2], m_mlc[0], m_mlc[1]};
        return {ext_dcd_n, ext_ri_n, ~m_mlc[0] ^ flip, ~m_mlc[1] ^ flip};
    endfunction : e_ints

    function automatic logic [31:0] e_reg(input logic [3:0] a);
        case (a)
            UMCL_OFS_MLC: return {24'h0, 3'h7, m_mlc};
            UMCL_OFS_SPC: return {31'h0, m_wrap};
            UMCL_OFS_IER: return {28'h0, m_ier};
            UMCL_OFS_MSR: return {28'h0, ~e_ints()};
            default: return 32'h0;
        endcase
    endfunction : e_reg

    task automatic rd(input logic [3:0] a);
        bus(1'b0, a, 32'h0, 4'hF);
        chk_word("readdata", e_reg(a), q);
    endtask : rd

    task automatic chk_pins();
        logic g;
        g = m_mlc[4] ? m_wrap : m_mlc[3];
        chk_bit("rts_n", ~m_mlc[1], rts_n);
        chk_bit("dtr_n", ~m_mlc[0], dtr_n);
        chk_bit("loop_active", m_mlc[4], loop_active);
        chk_word("ints", e_ints(),
                 {dcd_n_int, ri_n_int, dsr_n_int, cts_n_int});
        chk_bit("port_irq", |(m_ier & irq_sources) & g, port_irq);
    endtask : chk_pins

    // Random transmit stream; the far side wiggles its receive pin in loop
    task automatic stream();
        logic h1, h2, b;
        h1 = tx_serial_in;
        h2 = tx_serial_in;
        for (int i = 0; i < 12; i++) begin
            @(posedge sys_clk);
            if (i >= 2) begin
                chk_bit("tx_pin", m_mlc[4] | h2, tx_pin);
                chk_bit("rx_data_out", m_mlc[4] ? h2 : ext_rx,
                        rx_data_out);
            end
            b = 1'($urandom);
            h2 = h1;
            h1 = b;
            tx_serial_in <= b;
            // Last edge left to the caller, which sets ext_rx itself
            if (m_mlc[4] && i < 11) ext_rx <= 1'($urandom);
        end
    endtask : stream

    ////////////////////////////////////////
    // Main sequence
    initial begin
        void'($urandom(32'hD3F83819));
        repeat (4) @(posedge sys_clk);
        resetn <= 1'b1;
        rd(UMCL_OFS_MLC);
        rd(UMCL_OFS_SPC);
        rd(UMCL_OFS_IER);
        chk_pins();
        $display("reset test done");
        wr(UMCL_OFS_MLC, 32'h000000FF, 4'hF);
        rd(UMCL_OFS_MLC);
        wr(UMCL_OFS_MLC, 32'h00000000, 4'hE);
        wr(UMCL_OFS_MSR, 32'h000000FF, 4'hF);
        wr(4'h6, 32'h000000FF, 4'hF);
        rd(4'h6);
        rd(UMCL_OFS_MLC);
        $display("access test done");
        for (int i = 0; i < 16; i++) begin
            slow <= i[1];
            flip <= i[2];
            ext_ri_n <= 1'($urandom);
            ext_dcd_n <= 1'($urandom);
            ext_rx <= 1'($urandom);
            irq_sources <= 4'($urandom);
            wr(UMCL_OFS_SPC, {31'h0, 1'($urandom)}, 4'hF);
            wr(UMCL_OFS_IER, {28'h0, 4'($urandom)}, 4'hF);
            wr(UMCL_OFS_MLC, {24'h0, 3'($urandom), i[0], 4'($urandom)}, 4'hF);
            repeat (12) @(posedge sys_clk);
            chk_pins();
            rd(UMCL_OFS_MSR);
            stream();
        end
        $display("mode test done");
        // Clock enable low must hold the pin path where it stands
        wr(UMCL_OFS_MLC, 32'h00000000, 4'hF);
        tx_serial_in <= 1'b0;
        repeat (2) @(posedge sys_clk);
        clk_en <= 1'b0;
        tx_serial_in <= 1'b1;
        repeat (4) @(posedge sys_clk);
        chk_bit("tx_pin", 1'b0, tx_pin);
        clk_en <= 1'b1;
        repeat (2) @(posedge sys_clk);
        chk_bit("tx_pin", 1'b1, tx_pin);
        $display("freeze test done");
        test_done();
    end
endmodule : umcl_modem_ctrl_tb

// *** umcl_modem_partner.sv ***
/*
 * Far-side modem model: echoes the handshake outputs back promptly or
 * four edges late, and passes the other pin levels that the bench picks.
 * Assumes one clock with the device; flip models a faulty modem.
 */
module umcl_modem_partner (
    input wire logic sys_clk,
    input wire logic slow,
    input wire logic flip,
    input wire logic ext_rx,
    input wire logic ext_ri_n,
    input wire logic ext_dcd_n,
    input wire logic rts_n,
    input wire logic dtr_n,
    output logic cts_pin_n,
    output logic dsr_pin_n,
    output logic ri_pin_n,
    output logic dcd_pin_n,
    output logic rx_pin
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] rts_q = 4'hF;
    logic [3:0] dtr_q = 4'hF;

    ////////////////////////////////////////
    // Handshake echo; a slow modem answers late, so settle before checks
    always_ff @(posedge sys_clk) begin
        rts_q <= {rts_q[2:0], rts_n};
        dtr_q <= {dtr_q[2:0], dtr_n};
        cts_pin_n <= (slow ? rts_q[3] : rts_n) ^ flip;
        dsr_pin_n <= (slow ? dtr_q[3] : dtr_n) ^ flip;
        ri_pin_n <= ext_ri_n;
        dcd_pin_n <= ext_dcd_n;
        rx_pin <= ext_rx;
    end
endmodule : umcl_modem_partner

// *** umcl_pin_sync.sv ***
/*
 * Two-flop synchroniser bank for pins that arrive from outside the
 * clock domain. Assumes inputs idle high, so both stages reset to one.
 */
module umcl_pin_sync #(
    parameter int WIDTH = 1
) (
    input wire logic sys_clk,
    input wire logic resetn,
    input wire logic clk_en,
    input wire logic [WIDTH-1:0] async_in,
    output logic [WIDTH-1:0] sync_out
);
    import umcl_pkg::*;

    ////////////////////////////////////////////////////////////////////////
    // One pair of flops per pin; the first stage feeds only the second
    genvar gi;
    generate
        for (gi = 0; gi < WIDTH; gi++) begin : g_sync
            logic stage1;
            always_ff @(posedge sys_clk) begin
                if (!resetn) begin
                    stage1 <= UMCL_PIN_IDLE;
                    sync_out[gi] <= UMCL_PIN_IDLE;
                end else if (clk_en) begin
                    stage1 <= async_in[gi];
                    sync_out[gi] <= stage1;
                end
            end
        end
    endgenerate

endmodule : umcl_pin_sync

// *** umcl_pkg.sv ***
/*
 * Constants shared by the modem-control and loopback block: register
 * offsets, field positions, reset values, pin idle level and bus states.
 * Assumes a byte-addressed Avalon-MM slave with 32-bit data words.
 */
package umcl_pkg;

    ////////////////////////////////////////////////////////////////////////
    // Register byte offsets
    localparam logic [3:0] UMCL_OFS_MLC = 4'h0;
    localparam logic [3:0] UMCL_OFS_SPC = 4'h4;
    localparam logic [3:0] UMCL_OFS_IER = 4'h8;
    localparam logic [3:0] UMCL_OFS_MSR = 4'hC;

    ////////////////////////////////////////////////////////////////////////
    // Modem line control fields
    localparam int UMCL_MLC_DTR = 0;
    localparam int UMCL_MLC_RTS = 1;
    localparam int UMCL_MLC_AUX = 2;
    localparam int UMCL_MLC_GATE = 3;
    localparam int UMCL_MLC_LOOP = 4;
    localparam int UMCL_MLC_W = 5;
    localparam logic [UMCL_MLC_W-1:0] UMCL_MLC_RESET = 5'h00;
    localparam logic [2:0] UMCL_MLC_RSVD = 3'h7;

    ////////////////////////////////////////////////////////////////////////
    // Serial port control and interrupt enable fields
    localparam int UMCL_SPC_WRAP_IE = 0;
    localparam logic UMCL_SPC_RESET = 1'h0;
    localparam int UMCL_IER_W = 4;
    localparam logic [UMCL_IER_W-1:0] UMCL_IER_RESET = 4'h0;

    ////////////////////////////////////////////////////////////////////////
    // Modem status fields, read as active-high
    localparam int UMCL_MSR_CTS = 0;
    localparam int UMCL_MSR_DSR = 1;
    localparam int UMCL_MSR_RI = 2;
    localparam int UMCL_MSR_DCD = 3;

    ////////////////////////////////////////////////////////////////////////
    // Pin idle level and bus state machine
    localparam logic UMCL_PIN_IDLE = 1'h1;

    typedef enum logic [1:0] {
        UMCL_BUS_IDLE = 2'b01,
        UMCL_BUS_ACK = 2'b10
    } umcl_bus_state_type;

endpackage : umcl_pkg
